/* logic/faac_arm_ctrl.sv */
// frame acquisition arming control with apb register access
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "faac_map.svh"

module faac_arm_ctrl
  import faac_pkg::*;
#(
  parameter int          COUNT_W      = 16,
  parameter [COUNT_W-1:0] FCOUNT_RESET = 1
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        acq_trig_in,
  input  wire logic        frame_trig_in,
  input  wire logic        frame_done,
  output var  logic        frame_start,
  output var  logic        armed,
  output var  logic        frame_active
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  faac_state_type            state;
  faac_state_type            next_state;
  logic [`FAAC_CTRL_W-1:0]   ctrl_shadow;
  logic [`FAAC_CTRL_W-1:0]   ctrl_active;
  logic [COUNT_W-1:0]        frames_per_arm;
  logic [COUNT_W-1:0]        frame_count;
  logic                      stop_pending;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic        access;
  logic        wr_commit;
  logic        mapped;
  logic        cmd_arm;
  logic        cmd_disarm;
  logic        sw_acq;
  logic        sw_frm;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `FAAC_OFS_CTRL)   || (a == `FAAC_OFS_CMD) ||
               (a == `FAAC_OFS_FCOUNT) || (a == `FAAC_OFS_STATUS) ||
               (a == `FAAC_OFS_ACTIVE);
  endfunction : addr_hit

  // access is the first access cycle only; pready closes the second
  assign access    = psel && penable && !pready;
  // writes land only at the edge that completes the transfer
  assign wr_commit = psel && penable && pready && pwrite && !pslverr;
  assign mapped    = addr_hit(paddr);

  function automatic logic cmd_bit(input int b);
    cmd_bit = wr_commit && (paddr == `FAAC_OFS_CMD) && pstrb[`FAAC_CFG_LANE] && pwdata[b];
  endfunction : cmd_bit

  // status layout kept in one place beside the field map
  function automatic logic [31:0] status_word(input faac_state_type     st,
                                              input logic               pend,
                                              input logic [COUNT_W-1:0] cnt);
    status_word                                      = 32'h0000_0000;
    status_word[`FAAC_ST_ARMED]                      = (st != faac_unarmed);
    status_word[`FAAC_ST_STATE_HI:`FAAC_ST_STATE_LO] = st;
    status_word[`FAAC_ST_STOPPEND]                   = pend;
    status_word[`FAAC_ST_COUNT_LO +: COUNT_W]        = cnt;
  endfunction : status_word

  assign cmd_arm    = cmd_bit(`FAAC_CMD_ARM);
  assign cmd_disarm = cmd_bit(`FAAC_CMD_DISARM);
  assign sw_acq     = cmd_bit(`FAAC_CMD_SW_ACQ);
  assign sw_frm     = cmd_bit(`FAAC_CMD_SW_FRM);

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= access;
      pslverr <= access && !mapped;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (access && !pwrite) begin
        case (paddr)
          `FAAC_OFS_CTRL:   prdata <= {{(32-`FAAC_CTRL_W){1'b0}}, ctrl_shadow};
          `FAAC_OFS_FCOUNT: prdata <= {{(32-COUNT_W){1'b0}}, frames_per_arm};
          `FAAC_OFS_ACTIVE: prdata <= {{(32-`FAAC_CTRL_W){1'b0}}, ctrl_active};
          `FAAC_OFS_STATUS: prdata <= status_word(state, stop_pending, frame_count);
          default:          prdata <= 32'h0000_0000;
        endcase
      end else if (access) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      // RL4: legacy at reset
      ctrl_shadow <= `FAAC_CTRL_RESET;
    end else if (clk_en) begin
      // RL1: scheme select written
      if (wr_commit && paddr == `FAAC_OFS_CTRL && pstrb[`FAAC_CFG_LANE]) begin
        ctrl_shadow <= pwdata[`FAAC_CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frames_per_arm <= FCOUNT_RESET;
    end else if (clk_en) begin
      if (wr_commit && paddr == `FAAC_OFS_FCOUNT) begin
        // zero would never end a burst, so it is held at one
        frames_per_arm <= (pwdata[COUNT_W-1:0] == '0) ?
                          COUNT_W'(1) : pwdata[COUNT_W-1:0];
      end
    end
  end

  // limitation: a CTRL value written while armed waits until the block is next unarmed (disarm or lapse)
  // shadow copied only while idle, so a running frame never sees a change
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrl_active <= `FAAC_CTRL_RESET;
    end else if (clk_en) begin
      // RL15: apply while unarmed
      if (state == faac_unarmed) begin
        ctrl_active <= ctrl_shadow;
      end
    end
  end

  // ----------------------------------------
  // trigger selection
  // ----------------------------------------
  logic legacy;
  logic freerun;
  logic acq_stage;
  logic acq_evt;
  logic frm_evt;

  assign legacy  = ctrl_active[`FAAC_CTRL_LEGACY];
  assign freerun = ctrl_active[`FAAC_CTRL_FREERUN];
  // RL2: legacy drops acquisition stage
  assign acq_stage = !legacy && ctrl_active[`FAAC_CTRL_ACQ_ON];
  assign acq_evt   = acq_trig_in || sw_acq;

  always_comb begin
    // RL14: gating off fires internally
    if (!ctrl_active[`FAAC_CTRL_FRM_ON]) begin
      frm_evt = 1'b1;
    end else if (legacy) begin
      // RL3: legacy frame trigger on acq label
      frm_evt = acq_trig_in || sw_acq;
    end else begin
      frm_evt = frame_trig_in || sw_frm;
    end
  end

  // ----------------------------------------
  // arming state machine
  // ----------------------------------------
  // only counted with the acquisition stage; free-run alone never rewinds
  logic burst_done;
  assign burst_done = acq_stage && (frame_count == frames_per_arm);

  always_comb begin
    next_state = state;
    case (state)
      faac_unarmed: begin
        // RL5: capture needs arm
        if (cmd_arm) begin
          next_state = acq_stage ? faac_wait_acq : faac_wait_frame;
        end
      end
      faac_wait_acq: begin
        // RL11: idle disarm is immediate
        if (cmd_disarm) begin
          next_state = faac_unarmed;
        // RL12: acq trigger opens frame window
        end else if (acq_evt) begin
          next_state = faac_wait_frame;
        end
      end
      faac_wait_frame: begin
        if (cmd_disarm) begin
          next_state = faac_unarmed;
        // RL13: frame trigger only here
        end else if (frm_evt) begin
          next_state = faac_busy;
        end
      end
      faac_busy: begin
        if (frame_done) begin
          // RL6: one-shot lapses after frame
          if (!freerun) begin
            next_state = faac_unarmed;
          // RL10: disarm blocks further frames
          end else if (stop_pending || cmd_disarm) begin
            next_state = faac_unarmed;
          // RL12: count reached, back to acq wait
          end else if (burst_done) begin
            next_state = faac_wait_acq;
          end else begin
            // RL8: free-running stays armed
            next_state = faac_wait_frame;
          end
        end
      end
      default: next_state = faac_unarmed;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state <= faac_unarmed;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // frame_done with disarm ends the frame at once, nothing left pending
  // RL11: disarm mid-frame deferred
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stop_pending <= 1'b0;
    end else if (clk_en) begin
      if (state == faac_busy && !frame_done && cmd_disarm) begin
        stop_pending <= 1'b1;
      end else if (next_state == faac_unarmed) begin
        stop_pending <= 1'b0;
      end
    end
  end

  // counted at the trigger edge so status shows the frame in flight
  // RL12: frames since acquisition trigger
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_count <= '0;
    end else if (clk_en) begin
      if (state == faac_wait_acq || state == faac_unarmed) begin
        frame_count <= '0;
      end else if (state == faac_wait_frame && next_state == faac_busy) begin
        frame_count <= frame_count + COUNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // RL5: start only from frame wait
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_start <= 1'b0;
    end else if (clk_en) begin
      frame_start <= (state == faac_wait_frame) && (next_state == faac_busy);
    end
  end

  // RL9: armed until disarm or lapse
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (clk_en) begin
      armed <= (next_state != faac_unarmed);
    end
  end

  // RL11: active until frame done
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_active <= 1'b0;
    end else if (clk_en) begin
      frame_active <= (next_state == faac_busy);
    end
  end

endmodule : faac_arm_ctrl
`default_nettype wire

/* logic/faac_map.svh */
// register map, field positions and reset values for arming control
//
// Behaviour
// RL1: two schemes, standard and legacy, selectable
// RL2: legacy scheme omits acquisition trigger stage
// RL3: legacy frame trigger comes via acquisition label
// RL4: factory reset selects legacy scheme
// RL5: no capture while unarmed
// RL6: one-shot: one frame, then arm lapses
// RL7: host re-arms after each one-shot frame
// RL8: free-running: arm survives each frame
// RL9: free-running arm ends only on disarm
// RL10: after disarm, nothing until next arm
// RL11: disarm waits for frame in progress
// RL12: acquisition trigger enables counted frame triggers
// RL13: frame trigger ignored unless waiting for it
// RL14: gating off means internal trigger generation
// RL15: scheme and policy change only while unarmed
`ifndef FAAC_MAP_SVH
`define FAAC_MAP_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define FAAC_OFS_CTRL    8'h00
`define FAAC_OFS_CMD     8'h04
`define FAAC_OFS_FCOUNT  8'h08
`define FAAC_OFS_STATUS  8'h0c
`define FAAC_OFS_ACTIVE  8'h10

// ----------------------------------------
// control fields
// ----------------------------------------
`define FAAC_CTRL_LEGACY   0
`define FAAC_CTRL_FREERUN  1
`define FAAC_CTRL_ACQ_ON   2
`define FAAC_CTRL_FRM_ON   3
`define FAAC_CTRL_W        4
`define FAAC_CTRL_RESET    4'h1

// ----------------------------------------
// command fields
// ----------------------------------------
`define FAAC_CMD_ARM       0
`define FAAC_CMD_DISARM    1
`define FAAC_CMD_SW_ACQ    2
`define FAAC_CMD_SW_FRM    3
`define FAAC_CFG_LANE      0

// ----------------------------------------
// status fields
// ----------------------------------------
`define FAAC_ST_ARMED      0
`define FAAC_ST_STATE_LO   1
`define FAAC_ST_STATE_HI   2
`define FAAC_ST_STOPPEND   3
`define FAAC_ST_COUNT_LO   16

`endif

/* logic/faac_pkg.sv */
// types shared by the arming control block
`default_nettype none
package faac_pkg;
  typedef enum logic [1:0] {
    faac_unarmed    = 2'b00,
    faac_wait_acq   = 2'b01,
    faac_wait_frame = 2'b10,
    faac_busy       = 2'b11
  } faac_state_type;
endpackage : faac_pkg
`default_nettype wire

/* tb/faac_pipe_model.sv */
// capture pipeline model answering each frame start with a done pulse
`timescale 1ns/100ps
`default_nettype none
module faac_pipe_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [7:0] delay,
  input  wire logic       frame_start,
  output var  logic       frame_done
);
  // --------
  // frame timing
  // --------
  logic [7:0] left;
  logic       busy;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy       <= 1'b0;
      left       <= 8'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= busy && left == 8'h00;
      if (frame_start) begin
        busy <= 1'b1;
        left <= delay;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end else begin
        busy <= 1'b0;
      end
    end
  end
endmodule : faac_pipe_model
`default_nettype wire

/* tb/faac_arm_checker.sv */
// port assertions for the arming control block
`timescale 1ns/100ps
`default_nettype none
`include "faac_map.svh"
module faac_arm_checker (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       frame_done,
  input wire logic       frame_start,
  input wire logic       armed,
  input wire logic       frame_active
);
  // --------
  // properties
  // --------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_end; frame_active && frame_done; endsequence
  chk_apb_wait: assert property (s_wait |=> pready)
    else $error("access not answered after one wait");
  chk_setup_idle: assert property (psel && !penable |-> !pready)
    else $error("ready during setup");
  chk_apb_err: assert property (pready |-> pslverr == !(paddr inside {`FAAC_OFS_CTRL,
    `FAAC_OFS_CMD, `FAAC_OFS_FCOUNT, `FAAC_OFS_STATUS, `FAAC_OFS_ACTIVE}))
    else $error("error flag wrong for address");
  chk_start_armed: assert property (frame_start |-> $past(armed))
    else $error("frame started while unarmed");
  chk_unarmed_idle: assert property (!armed |=> !frame_start)
    else $error("frame start after unarmed cycle");
  chk_start_pulse: assert property (frame_start |-> frame_active ##1 !frame_start)
    else $error("frame start not a single pulse");
  chk_active_hold: assert property (frame_active && !frame_done |=> frame_active)
    else $error("frame dropped before done");
  chk_frame_end: assert property (s_end |=> !frame_active)
    else $error("frame still active after done");
  chk_active_rise: assert property ($rose(frame_active) |-> frame_start)
    else $error("frame active without start");
endmodule : faac_arm_checker
bind faac_arm_ctrl faac_arm_checker i_faac_arm_checker (
  .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .frame_done(frame_done),
  .frame_start(frame_start), .armed(armed), .frame_active(frame_active));
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the arming control block
`timescale 1ns/100ps
`default_nettype none
`include "faac_map.svh"
module testbench;
  logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic        acq_trig_in = 0, frame_trig_in = 0, frame_done, frame_start;
  logic        pready, pslverr, armed, frame_active;
  logic [7:0]  paddr = 0, dly = 8'h05;
  logic [31:0] pwdata = 0, prdata, rd;
  int          mismatches = 0, checks_done = 0, starts = 0, s0;
  // write flag, address, data, expected read, expected error
  logic [73:0] rows [10] = '{{1'b0, `FAAC_OFS_CTRL, 32'h0, 32'h1, 1'b0},
    {1'b0, `FAAC_OFS_FCOUNT, 32'h0, 32'h1, 1'b0}, {1'b0, `FAAC_OFS_STATUS, 32'h0, 32'h0, 1'b0},
    {1'b1, `FAAC_OFS_FCOUNT, 32'h0, 32'h1, 1'b0}, {1'b1, `FAAC_OFS_FCOUNT, 32'h3, 32'h3, 1'b0},
    {1'b1, `FAAC_OFS_CTRL, 32'he, 32'he, 1'b0}, {1'b0, `FAAC_OFS_ACTIVE, 32'h0, 32'he, 1'b0},
    {1'b0, `FAAC_OFS_CMD, 32'h0, 32'h0, 1'b0}, {1'b1, 8'h14, 32'h5, 32'h0, 1'b1},
    {1'b0, 8'h02, 32'h0, 32'h0, 1'b1}};
  // --------
  // harness
  // --------
  faac_arm_ctrl i_faac_arm_ctrl (
    .sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .acq_trig_in(acq_trig_in),
    .frame_trig_in(frame_trig_in), .frame_done(frame_done), .frame_start(frame_start),
    .armed(armed), .frame_active(frame_active));
  faac_pipe_model i_faac_pipe_model (.sys_clk(sys_clk), .reset(reset), .delay(dly),
    .frame_start(frame_start), .frame_done(frame_done));
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (frame_start === 1'b1) starts <= starts + 1;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // only the watchdog ends a transfer that never completes
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // triggers held one cycle, then time for a short frame to finish
  task trig(input logic a);
    @(posedge sys_clk);
    if (a) begin
      acq_trig_in <= 1'b1;
    end else begin
      frame_trig_in <= 1'b1;
    end
    @(posedge sys_clk);
    acq_trig_in <= 0;
    frame_trig_in <= 0;
    repeat (8) @(posedge sys_clk);
  endtask : trig
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    finish_test();
  end
  // --------
  // sequence
  // --------
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 0;
    foreach (rows[i]) begin
      if (rows[i][73]) apb(1, rows[i][72:65], rows[i][64:33]);
      apb(0, rows[i][72:65], 0);
      chk(rd, rows[i][32:1]);
      chk(er, rows[i][0]);
    end
    apb(1, `FAAC_OFS_CTRL, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk(starts, 0);
    apb(1, `FAAC_OFS_CMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk(starts, 1);
    chk(armed, 0);
    apb(1, `FAAC_OFS_CMD, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk(starts, 2);
    dly <= 8'h28;
    apb(1, `FAAC_OFS_CTRL, 32'h3);
    apb(1, `FAAC_OFS_CMD, 32'h1);
    repeat (150) @(posedge sys_clk);
    chk(starts > 4, 1);
    chk(armed, 1);
    s0 = 0;
    while (frame_start !== 1'b1 && s0 < 99) begin
      @(posedge sys_clk);
      s0++;
    end
    chk(s0 < 99, 1);
    apb(1, `FAAC_OFS_CMD, 32'h2);
    chk(frame_active, 1);
    apb(0, `FAAC_OFS_STATUS, 0);
    chk(rd[3], 1);
    repeat (60) @(posedge sys_clk);
    s0 = starts;
    chk(frame_active, 0);
    chk(armed, 0);
    repeat (60) @(posedge sys_clk);
    chk(starts, s0);
    dly <= 8'h03;
    apb(1, `FAAC_OFS_FCOUNT, 32'h2);
    apb(1, `FAAC_OFS_CTRL, 32'he);
    apb(1, `FAAC_OFS_CMD, 32'h1);
    s0 = starts;
    trig(0);
    chk(starts, s0);
    trig(1);
    repeat (3) trig(0);
    chk(starts, s0 + 2);
    apb(1, `FAAC_OFS_CTRL, 32'h1);
    apb(0, `FAAC_OFS_ACTIVE, 0);
    chk(rd, 32'he);
    apb(0, `FAAC_OFS_STATUS, 0);
    chk(rd[2:1], 2'h1);
    apb(1, `FAAC_OFS_CMD, 32'h4);
    apb(1, `FAAC_OFS_CMD, 32'h8);
    repeat (8) @(posedge sys_clk);
    chk(starts, s0 + 3);
    apb(1, `FAAC_OFS_CMD, 32'h2);
    apb(1, `FAAC_OFS_CTRL, 32'hb);
    apb(1, `FAAC_OFS_CMD, 32'h1);
    s0 = starts;
    trig(0);
    chk(starts, s0);
    trig(1);
    chk(starts, s0 + 1);
    apb(1, `FAAC_OFS_CMD, 32'h4);
    repeat (8) @(posedge sys_clk);
    chk(starts, s0 + 2);
    // reset in mid-run brings back the factory defaults
    reset <= 1'b1;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    chk(armed, 0);
    apb(0, `FAAC_OFS_CTRL, 0);
    chk(rd, 32'h1);
    apb(0, `FAAC_OFS_FCOUNT, 0);
    chk(rd, 32'h1);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
